// file: design/sbg_pkg.sv
// sbg_pkg: constants for the transmit status bit generator
// assumes a wishbone slave with 32-bit data, byte addresses = 4 x register index
package sbg_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL_ZERO   = 8'h1e;
    localparam logic [7:0] IDX_CONTROL_ONE    = 8'h1f;
    localparam logic [7:0] IDX_CATEGORY       = 8'h20;
    localparam logic [7:0] IDX_SOURCE_CHANNEL = 8'h21;
    localparam logic [7:0] IDX_RATE_ACCURACY  = 8'h22;
    localparam logic [7:0] IDX_WORD_LENGTH    = 8'h23;
    localparam logic [7:0] IDX_STATUS         = 8'h24;
    // reset values
    localparam logic [7:0] RST_CONTROL_ZERO   = 8'h00;
    localparam logic [7:0] RST_CONTROL_ONE    = 8'h00;
    localparam logic [7:0] RST_CATEGORY       = 8'h00;
    localparam logic [7:0] RST_SOURCE_CHANNEL = 8'h00;
    localparam logic [7:0] RST_RATE_ACCURACY  = 8'h31;
    localparam logic [7:0] RST_WORD_LENGTH    = 8'h0b;
    // control zero field positions
    localparam int POS_SRC_LO       = 0;
    localparam int POS_SRC_HI       = 1;
    localparam int POS_STAT_OVR     = 2;
    localparam int POS_VAL_OVR      = 4;
    localparam int POS_VAL_SUB0     = 5;
    localparam int POS_VAL_SUB1     = 6;
    // source number / channel number field positions
    localparam int POS_SUB1_CHANNEL_NUMBER_LO    = 4;
    localparam int POS_SUB2_CHANNEL_NUMBER_LO    = 6;
    // channel status geometry
    localparam int CS_BLOCK_LEN     = 192;
    localparam int CS_USED_BITS     = 40;
    localparam int CS_CHNUM_LO      = 20;
    localparam int CS_CHNUM_HI      = 23;
    typedef enum logic [1:0] {
        SBG_SRC_RECEIVER,
        SBG_SRC_ADC,
        SBG_SRC_SECONDARY,
        SBG_SRC_PRIMARY
    } sbg_src_t;
endpackage

// file: design/sbg_status_bit_gen.sv
// sbg_status_bit_gen: validity, user, channel status and parity per sub-frame
// assumes a frame sequencer on clk_i that pulses sub_strobe_i once per sub-frame
// with the receiver's recovered bits and the payload parity already valid
//
// Operation
// - validity is zero by default
// - receiver source repeats recovered validity
// - validity override uses per-sub-frame settings first
// - user bit is zero by default
// - receiver source repeats recovered user bit
// - one status bit per sub-frame, 192-frame blocks
// - only first 40 status bits configured
// - both sub-frames equal except bits 23:20
// - receiver status repeated unless override set
// - parity gives even parity over sub-frame
// - status bit 0 is consumer flag
// - status bit 1 is non-pcm flag
// - status bit 2 is copy flag
// - status bits 5:3 hold emphasis code
// - status bits 7:6 hold status mode
// - status bits 15:8 hold category
// - channel numbers at 21:20 and 23:22
// - status bits 27:24 hold sample rate code
// - status bits 29:28 hold clock accuracy
// - two-bit source select picks frame origin
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module sbg_status_bit_gen
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // classic wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    // sub-frame timing from the frame sequencer
    input  wire logic        sub_strobe_i,
    input  wire logic        sub_index_i,
    input  wire logic        block_start_i,
    input  wire logic        payload_parity_i,
    // bits recovered by the receiver for this sub-frame
    input  wire logic        rx_validity_i,
    input  wire logic        rx_user_i,
    input  wire logic        rx_status_i,
    // bits to insert
    output logic             validity_o,
    output logic             user_o,
    output logic             status_o,
    output logic             parity_o,
    output logic             bits_valid_o,
    output logic      [1:0]  tx_source_select_o
);

    logic [7:0] ctrl_zero_reg;
    logic [7:0] ctrl_one_reg;
    logic [7:0] category_reg;
    logic [7:0] src_chan_reg;
    logic [7:0] rate_acc_reg;
    logic [7:0] word_len_reg;
    logic [7:0] frame_pos_reg;
    logic [7:0] frame_pos_next;
    logic       ack_reg;
    logic       err_reg;
    logic [31:0] rdata_reg;
    logic       validity_reg;
    logic       user_reg;
    logic       status_reg;
    logic       parity_reg;
    logic       bits_valid_reg;

    // word address of a register index; upper address bits must be zero to hit
    function automatic logic [29:0] word_of(input logic [7:0] idx);
        return {22'h000000, idx};
    endfunction

    // register bus decode
    // a request is taken only while no answer is out, so a held strobe is not answered in two cycles in a row
    wire        bus_req    = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    wire [29:0] word_index = wb_adr_i[31:2];
    wire        hit_c0     = (word_index == word_of(sbg_pkg::IDX_CONTROL_ZERO));
    wire        hit_c1     = (word_index == word_of(sbg_pkg::IDX_CONTROL_ONE));
    wire        hit_cat    = (word_index == word_of(sbg_pkg::IDX_CATEGORY));
    wire        hit_sc     = (word_index == word_of(sbg_pkg::IDX_SOURCE_CHANNEL));
    wire        hit_ra     = (word_index == word_of(sbg_pkg::IDX_RATE_ACCURACY));
    wire        hit_wl     = (word_index == word_of(sbg_pkg::IDX_WORD_LENGTH));
    wire        hit_st     = (word_index == word_of(sbg_pkg::IDX_STATUS));
    wire        hit_any    = hit_c0 || hit_c1 || hit_cat || hit_sc || hit_ra || hit_wl || hit_st;
    // only byte lane 0 carries data; other lanes are ignored
    wire        wr_lane0   = bus_req && wb_we_i && wb_sel_i[0];

    logic [7:0] rd_mux;
    always_comb
    begin
        if (hit_c0)
            rd_mux = ctrl_zero_reg;
        else if (hit_c1)
            rd_mux = ctrl_one_reg;
        else if (hit_cat)
            rd_mux = category_reg;
        else if (hit_sc)
            rd_mux = src_chan_reg;
        else if (hit_ra)
            rd_mux = rate_acc_reg;
        else if (hit_wl)
            rd_mux = word_len_reg;
        else if (hit_st)
            rd_mux = frame_pos_reg;
        else
            rd_mux = 8'h00;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end
        else
        begin
            ack_reg   <= bus_req && hit_any;
            err_reg   <= bus_req && !hit_any;
            rdata_reg <= {24'h000000, rd_mux};
        end
    end

    // configuration registers; status word is read only
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_zero_reg <= sbg_pkg::RST_CONTROL_ZERO;
            ctrl_one_reg  <= sbg_pkg::RST_CONTROL_ONE;
            category_reg  <= sbg_pkg::RST_CATEGORY;
            src_chan_reg  <= sbg_pkg::RST_SOURCE_CHANNEL;
            rate_acc_reg  <= sbg_pkg::RST_RATE_ACCURACY;
            word_len_reg  <= sbg_pkg::RST_WORD_LENGTH;
        end
        else if (wr_lane0)
        begin
            if (hit_c0)
                ctrl_zero_reg <= wb_dat_i[7:0];
            if (hit_c1)
                ctrl_one_reg <= wb_dat_i[7:0];
            if (hit_cat)
                category_reg <= wb_dat_i[7:0];
            if (hit_sc)
                src_chan_reg <= wb_dat_i[7:0];
            if (hit_ra)
                rate_acc_reg <= wb_dat_i[7:0];
            if (hit_wl)
                word_len_reg <= wb_dat_i[7:0];
        end
    end

    // control fields
    wire [1:0] tx_source_select       = ctrl_zero_reg[sbg_pkg::POS_SRC_HI:sbg_pkg::POS_SRC_LO];
    wire       from_receiver          = (tx_source_select == 2'(sbg_pkg::SBG_SRC_RECEIVER));
    wire       status_override_enable = ctrl_zero_reg[sbg_pkg::POS_STAT_OVR];
    wire       validity_override_enable = ctrl_zero_reg[sbg_pkg::POS_VAL_OVR];
    wire       validity_value_sub0    = ctrl_zero_reg[sbg_pkg::POS_VAL_SUB0];
    wire       validity_value_sub1    = ctrl_zero_reg[sbg_pkg::POS_VAL_SUB1];
    wire [1:0] sub1_channel_number    = src_chan_reg[sbg_pkg::POS_SUB1_CHANNEL_NUMBER_LO +: 2];
    wire [1:0] sub2_channel_number    = src_chan_reg[sbg_pkg::POS_SUB2_CHANNEL_NUMBER_LO +: 2];

    // named status fields; consumer flag, mode and emphasis are sent as written,
    // software keeps them legal since no hardware check would help a receiver
    wire       pro_consumer_flag      = ctrl_one_reg[0];
    wire       non_pcm_flag           = ctrl_one_reg[1];
    wire       copy_permit_flag       = ctrl_one_reg[2];
    wire [2:0] emphasis_code          = ctrl_one_reg[5:3];
    wire [1:0] status_mode_code       = ctrl_one_reg[7:6];
    wire [7:0] category_field         = category_reg;
    wire [3:0] source_number_field    = src_chan_reg[3:0];
    wire [3:0] sample_rate_code       = rate_acc_reg[3:0];
    wire [1:0] clock_accuracy_code    = rate_acc_reg[5:4];
    wire       max_sample_length_flag = word_len_reg[0];
    wire [2:0] sample_length_code     = word_len_reg[3:1];
    wire [3:0] original_rate_code     = word_len_reg[7:4];

    // 40-bit configured status image; bits 23:20 are filled per sub-frame below
    wire [39:0] status_common = {original_rate_code,
                                 sample_length_code,
                                 max_sample_length_flag,
                                 2'b00,
                                 clock_accuracy_code,
                                 sample_rate_code,
                                 4'h0,
                                 source_number_field,
                                 category_field,
                                 status_mode_code,
                                 emphasis_code,
                                 copy_permit_flag,
                                 non_pcm_flag,
                                 pro_consumer_flag};

    // replace bits 23:20 with the sub-frame's own channel number
    function automatic logic [39:0] with_chnum(input logic [39:0] img, input logic [1:0] num);
        logic [39:0] r;
        r = img;
        r[sbg_pkg::CS_CHNUM_HI:sbg_pkg::CS_CHNUM_LO] = {num, num};
        return r;
    endfunction

    // each sub-frame carries its own number in both channel number slots
    wire [39:0] status_sub0 = with_chnum(status_common, sub1_channel_number);
    wire [39:0] status_sub1 = with_chnum(status_common, sub2_channel_number);

    // frame position within the block, shared by both sub-frame blocks
    wire at_block_start = sub_strobe_i && block_start_i && !sub_index_i;
    wire [7:0] cur_pos  = at_block_start ? 8'h00 : frame_pos_reg;

    always_comb
    begin
        frame_pos_next = frame_pos_reg;
        if (sub_strobe_i && sub_index_i)
        begin
            if (cur_pos == 8'(sbg_pkg::CS_BLOCK_LEN - 1))
                frame_pos_next = 8'h00;
            else
                frame_pos_next = cur_pos + 8'h01;
        end
        else if (at_block_start)
            frame_pos_next = 8'h00;
    end

    logic cfg_status_bit;
    logic val_bit;
    logic user_bit;
    logic stat_bit;

    // register image bit for this position; only the first 40 positions carry content
    always_comb
    begin
        cfg_status_bit = 1'b0;
        if (cur_pos < 8'(sbg_pkg::CS_USED_BITS))
        begin
            if (sub_index_i)
                cfg_status_bit = status_sub1[cur_pos[5:0]];
            else
                cfg_status_bit = status_sub0[cur_pos[5:0]];
        end
    end

    // validity: override first, then receiver, else valid
    always_comb
    begin
        val_bit = 1'b0;
        if (validity_override_enable)
        begin
            if (sub_index_i)
                val_bit = validity_value_sub1;
            else
                val_bit = validity_value_sub0;
        end
        else if (from_receiver)
            val_bit = rx_validity_i;
    end

    // user data cannot be configured, so only the receiver supplies it
    always_comb
    begin
        user_bit = 1'b0;
        if (from_receiver)
            user_bit = rx_user_i;
    end

    // status override only counts while the receiver is the source
    always_comb
    begin
        stat_bit = cfg_status_bit;
        if (from_receiver && !status_override_enable)
            stat_bit = rx_status_i;
    end
    // even parity over payload, v, u, c
    wire par_bit  = payload_parity_i ^ val_bit ^ user_bit ^ stat_bit;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            frame_pos_reg  <= 8'h00;
            validity_reg   <= 1'b0;
            user_reg       <= 1'b0;
            status_reg     <= 1'b0;
            parity_reg     <= 1'b0;
            bits_valid_reg <= 1'b0;
        end
        else
        begin
            frame_pos_reg  <= frame_pos_next;
            bits_valid_reg <= sub_strobe_i;
            if (sub_strobe_i)
            begin
                validity_reg <= val_bit;
                user_reg     <= user_bit;
                status_reg   <= stat_bit;
                parity_reg   <= par_bit;
            end
        end
    end

    assign wb_ack_o           = ack_reg;
    assign wb_err_o           = err_reg;
    assign wb_dat_o           = rdata_reg;
    assign validity_o         = validity_reg;
    assign user_o             = user_reg;
    assign status_o           = status_reg;
    assign parity_o           = parity_reg;
    assign bits_valid_o       = bits_valid_reg;
    assign tx_source_select_o = tx_source_select;

endmodule

// file: verif/sbg_props_properties.sv
// checker: port-level properties of the status bit generator
// assumes one clock, reset synchronous and active high
`timescale 1ns/1ps
module sbg_props
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        sub_strobe_i,
    input wire logic        payload_parity_i,
    input wire logic        rx_user_i,
    input wire logic        validity_o,
    input wire logic        user_o,
    input wire logic        status_o,
    input wire logic        parity_o,
    input wire logic        bits_valid_o,
    input wire logic [1:0]  tx_source_select_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // only aligned addresses are used, so a range test is enough
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire hit = wb_adr_i >= 32'h78 && wb_adr_i <= 32'h90;
    property p_ans; sub_strobe_i |=> bits_valid_o; endproperty
    a_ans: assert property (p_ans) else $error("no bits after strobe");
    property p_quiet; !sub_strobe_i |=> !bits_valid_o; endproperty
    a_quiet: assert property (p_quiet) else $error("bits without strobe");
    property p_hold; !sub_strobe_i |=> $stable({validity_o, user_o, status_o, parity_o}); endproperty
    a_hold: assert property (p_hold) else $error("bits moved between strobes");
    property p_par; bits_valid_o |-> parity_o == ($past(payload_parity_i) ^ validity_o ^ user_o ^ status_o); endproperty
    a_par: assert property (p_par) else $error("parity not even");
    property p_uzero; sub_strobe_i && tx_source_select_o != 2'h0 |=> !user_o; endproperty
    a_uzero: assert property (p_uzero) else $error("user bit not zero");
    property p_urx; sub_strobe_i && tx_source_select_o == 2'h0 |=> user_o == $past(rx_user_i); endproperty
    a_urx: assert property (p_urx) else $error("user bit not repeated");
    property p_ack; req && hit |=> wb_ack_o && !wb_err_o; endproperty
    a_ack: assert property (p_ack) else $error("mapped access not acked");
    property p_err; req && !hit |=> wb_err_o && !wb_ack_o; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_rd8; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_rd8: assert property (p_rd8) else $error("read data above byte");
endmodule
bind sbg_status_bit_gen sbg_props u_props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_adr_i, .wb_dat_o,
    .wb_ack_o, .wb_err_o, .sub_strobe_i, .payload_parity_i, .rx_user_i, .validity_o, .user_o,
    .status_o, .parity_o, .bits_valid_o, .tx_source_select_o);

// file: verif/sbg_rx_model.sv
// partner: receiving end that latches each inserted bit group
// assumes strobe_i marks the one cycle in which the bits are new
`timescale 1ns/1ps
module sbg_rx_model
(
    input  wire logic       clk_i,
    input  wire logic       strobe_i,
    input  wire logic [3:0] vucp_i,
    output logic      [3:0] got_o
);
    // latched on the strobe only, so bits are never read mid-change
    always_ff @(posedge clk_i)
        if (strobe_i)
            got_o <= vucp_i;
endmodule

// file: verif/tb.sv
// testbench: registers over wishbone, then whole blocks in every source mode
// assumes the design answers a bus request one cycle after taking it
`timescale 1ns/1ps
module tb;
    logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
    logic [3:0]  wb_sel_i = 4'hf, got;
    logic        wb_ack_o, wb_err_o, bits_valid_o, validity_o, user_o, status_o, parity_o, e;
    logic        sub_strobe_i = 1'h0, sub_index_i = 1'h0, block_start_i = 1'h0, payload_parity_i = 1'h0;
    logic        rx_validity_i = 1'h0, rx_user_i = 1'h0, rx_status_i = 1'h0;
    logic [1:0]  tx_source_select_o;
    logic [7:0]  rv [0:4];
    logic [7:0]  rd, cfg;
    int          err_count = 0, cmp_count = 0;
    always #10 clk_i = ~clk_i;
    sbg_status_bit_gen dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
        .wb_sel_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .sub_strobe_i, .sub_index_i, .block_start_i,
        .payload_parity_i, .rx_validity_i, .rx_user_i, .rx_status_i, .validity_o, .user_o,
        .status_o, .parity_o, .bits_valid_o, .tx_source_select_o);
    sbg_rx_model rx_u (.clk_i, .strobe_i(bits_valid_o), .vucp_i({validity_o, user_o, status_o, parity_o}),
        .got_o(got));
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        wb_adr_i <= {22'h0, idx, 2'h0};
        wb_dat_i <= {24'h0, wd};
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 20);
        if (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1)
        begin
            err_count++;
            finish_test();
        end
        rd = wb_dat_o[7:0];
        e = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    // each sub-frame position carries its own channel number
    function automatic logic [39:0] img(input logic idx);
        logic [1:0] ch;
        ch = idx ? rv[2][7:6] : rv[2][5:4];
        return {rv[4], 2'h0, rv[3][5:4], rv[3][3:0], ch, ch, rv[2][3:0], rv[1], rv[0]};
    endfunction
    task automatic sub(input logic idx, input logic bs, input int pos);
        logic [3:0]  r;
        logic [39:0] im;
        logic        rx, xv, xu, xc;
        r = 4'($urandom);
        im = img(idx);
        rx = cfg[1:0] == 2'h0;
        @(posedge clk_i);
        {sub_strobe_i, sub_index_i, block_start_i} <= {1'h1, idx, bs};
        {rx_validity_i, rx_user_i, rx_status_i, payload_parity_i} <= r;
        @(posedge clk_i);
        sub_strobe_i <= 1'h0;
        @(posedge clk_i);
        @(negedge clk_i);
        xv = cfg[4] ? cfg[5 + idx] : rx & r[3];
        xu = rx & r[2];
        xc = (rx && !cfg[2]) ? r[1] : (pos < 40 ? im[pos] : 1'h0);
        chk("vucp", {xv, xu, xc, ^{r[0], xv, xu, xc}}, got);
    endtask
    initial
    begin
        logic [7:0] modes [0:5] = '{8'h01, 8'h00, 8'h04, 8'h53, 8'h30, 8'h02};
        logic [7:0] rst_t [0:5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h0b};
        void'($urandom(32'hb3c7));
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        for (int i = 0; i < 6; i++)
        begin
            wb(1'h0, 8'(8'h1e + i), 8'h0);
            chk("reset value", rst_t[i], rd);
        end
        wb(1'h0, 8'h25, 8'h0);
        chk("unmapped err", 1'h1, e);
        foreach (modes[m])
        begin
            cfg = modes[m];
            rv[0] = 8'($urandom) & 8'h1e;
            for (int i = 1; i < 5; i++)
                rv[i] = 8'($urandom);
            wb(1'h1, 8'h1e, cfg);
            for (int i = 0; i < 5; i++)
                wb(1'h1, 8'(8'h1f + i), rv[i]);
            wb(1'h0, 8'h21, 8'h0);
            chk("readback", rv[2], rd);
            chk("source", cfg[1:0], tx_source_select_o);
            for (int pos = 0; pos < 192; pos++)
            begin
                sub(1'h0, pos == 0, pos);
                sub(1'h1, 1'h0, pos);
            end
            wb(1'h0, 8'h24, 8'h0);
            chk("frame position", 8'h00, rd);
        end
        finish_test();
    end
endmodule
